/* File: eirq_regs.svh */
// What this block does
// R1: Combined transmit line is high while any transmit channel pends outside a pacing holdoff.
// R2: Combined receive line is high while any receive channel pends outside a pacing holdoff.
// R3: Only channel-0 lines reach the processor interrupt controller.
// R4: Pacing acts only on the combined outputs; channel lines pass unpaced.
// R5: Integrator routes both combined outputs into two capture-mode timers.
// R6: Captured timer value is irrelevant; only the capture event matters.
// R7: Event 8 (combined receive) feeds first timer, event 9 the second.
// R8: Each rerouting timer uses single capture on the rising edge.
// R9: Software services receive on interrupt 93 and transmit on 94.
// R10: Combined output holds while any channel pends, drops once all clear.
`ifndef EIRQ_REGS_SVH
`define EIRQ_REGS_SVH

`define EIRQ_NUM_CH          8
`define EIRQ_CNT_W           16
`define EIRQ_CLK_PERIOD_NS   10
`define EIRQ_PACE_TIME_NS    1000
`define EIRQ_PACE_CYCLES \
  ((`EIRQ_PACE_TIME_NS + `EIRQ_CLK_PERIOD_NS - 1) / `EIRQ_CLK_PERIOD_NS)
`define EIRQ_RX_EVENT_NUM    8
`define EIRQ_TX_EVENT_NUM    9
`define EIRQ_RESET_LEVEL     1'b0

`endif

/* File: eirq_pkg.sv */
`include "eirq_regs.svh"

package eirq_pkg;

  typedef struct packed {
    logic [`EIRQ_NUM_CH-1:0] tx_channel_irq;
    logic [`EIRQ_NUM_CH-1:0] rx_channel_irq;
  } eirq_chan_t;

  typedef struct packed {
    logic tx0;
    logic rx0;
  } eirq_cpu_t;

  typedef struct packed {
    logic [3:0] tx_count;
    logic [3:0] rx_count;
    logic [2:0] tx_low_chan;
    logic [2:0] rx_low_chan;
    logic       tx_holdoff;
    logic       rx_holdoff;
  } eirq_status_t;

  typedef enum logic [2:0] {
    EIRQ_P_IDLE   = 3'b001,
    EIRQ_P_ACTIVE = 3'b010,
    EIRQ_P_HOLD   = 3'b100
  } eirq_pace_state_t;

endpackage : eirq_pkg

/* File: eirq_pacer.sv */
`timescale 1ns/1ps
`include "eirq_regs.svh"

module eirq_pacer #(
  parameter int unsigned CNT_W = `EIRQ_CNT_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             pend_any,
  input  wire logic             pace_en,
  input  wire logic [CNT_W-1:0] pace_cycles,
  output logic                  irq_out,
  output logic                  holdoff
);
  import eirq_pkg::*;

  eirq_pace_state_t state_reg;
  eirq_pace_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             irq_reg;

  wire hold_done = (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) || !pace_en;

  // Pacing only delays a new assertion; it never cuts one short, so a
  // channel that stays pending always keeps the combined line high.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      EIRQ_P_IDLE:
      begin
        if (pend_any)
          state_next = EIRQ_P_ACTIVE;
      end
      EIRQ_P_ACTIVE:
      begin
        if (!pend_any) // R10
        begin
          if (pace_en && (pace_cycles != '0)) // R4
          begin
            state_next = EIRQ_P_HOLD;
            cnt_next   = pace_cycles;
          end
          else
            state_next = EIRQ_P_IDLE;
        end
      end
      EIRQ_P_HOLD:
      begin
        if (hold_done)
        begin
          state_next = pend_any ? EIRQ_P_ACTIVE : EIRQ_P_IDLE;
          cnt_next   = '0;
        end
        else
          cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      default:
      begin
        state_next = EIRQ_P_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= EIRQ_P_IDLE;
      cnt_reg   <= '0;
      irq_reg   <= `EIRQ_RESET_LEVEL;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      irq_reg   <= (state_next == EIRQ_P_ACTIVE);
    end
  end

  assign irq_out = irq_reg;
  assign holdoff = (state_reg == EIRQ_P_HOLD);

endmodule : eirq_pacer

/* File: eirq_combine_top.sv */
`timescale 1ns/1ps
`include "eirq_regs.svh"

module eirq_combine_top #(
  parameter int unsigned CNT_W       = `EIRQ_CNT_W,
  parameter int unsigned PACE_CYCLES = `EIRQ_PACE_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire eirq_pkg::eirq_chan_t  chan_pend,
  input  wire logic                  pace_en_tx,
  input  wire logic                  pace_en_rx,
  output logic                       combined_tx_irq,
  output logic                       combined_rx_irq,
  output logic                       tx_capture_evt,
  output logic                       rx_capture_evt,
  output eirq_pkg::eirq_cpu_t        cpu_irq_controller,
  output eirq_pkg::eirq_chan_t       chan_pend_out,
  output eirq_pkg::eirq_status_t     status
);
  import eirq_pkg::*;

  localparam logic [CNT_W-1:0] PACE_LIMIT = CNT_W'(PACE_CYCLES);

  function automatic logic [3:0] count_pending(
    input logic [`EIRQ_NUM_CH-1:0] lines
  );
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < `EIRQ_NUM_CH; i++)
      n = n + {3'h0, lines[i]};
    return n;
  endfunction : count_pending

  function automatic logic [2:0] lowest_pending(
    input logic [`EIRQ_NUM_CH-1:0] lines
  );
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `EIRQ_NUM_CH - 1; i >= 0; i--)
      if (lines[i])
        idx = 3'(i);
    return idx;
  endfunction : lowest_pending

  // Channel lines come from logic on this same clock, so no synchroniser.
  wire tx_any = |chan_pend.tx_channel_irq; // R1
  wire rx_any = |chan_pend.rx_channel_irq; // R2

  wire [3:0] tx_cnt_w = count_pending(chan_pend.tx_channel_irq);
  wire [3:0] rx_cnt_w = count_pending(chan_pend.rx_channel_irq);
  wire [2:0] tx_low_w = lowest_pending(chan_pend.tx_channel_irq);
  wire [2:0] rx_low_w = lowest_pending(chan_pend.rx_channel_irq);

  logic tx_comb_w;
  logic rx_comb_w;
  logic tx_hold_w;
  logic rx_hold_w;

  eirq_pacer #(
    .CNT_W (CNT_W)
  ) u_tx_pacer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .pend_any    (tx_any),
    .pace_en     (pace_en_tx),
    .pace_cycles (PACE_LIMIT),
    .irq_out     (tx_comb_w),
    .holdoff     (tx_hold_w)
  );

  eirq_pacer #(
    .CNT_W (CNT_W)
  ) u_rx_pacer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .pend_any    (rx_any),
    .pace_en     (pace_en_rx),
    .pace_cycles (PACE_LIMIT),
    .irq_out     (rx_comb_w),
    .holdoff     (rx_hold_w)
  );

  logic         tx_prev_reg;
  logic         rx_prev_reg;
  logic         tx_evt_reg;
  logic         rx_evt_reg;
  eirq_cpu_t    cpu_reg;
  eirq_chan_t   chan_reg;
  eirq_status_t status_reg;

  // The capture pulse marks only the rising edge of a combined line; the
  // timer downstream latches a count that carries no meaning.
  wire tx_rise_w = tx_comb_w && !tx_prev_reg; // R6
  wire rx_rise_w = rx_comb_w && !rx_prev_reg; // R6

  eirq_cpu_t  cpu_next;
  eirq_status_t status_next;
  // One driver per struct keeps each variable with a single assignment.
  assign cpu_next = {chan_pend.tx_channel_irq[0],
                     chan_pend.rx_channel_irq[0]}; // R3
  assign status_next = {tx_cnt_w, rx_cnt_w, tx_low_w, rx_low_w,
                        tx_hold_w, rx_hold_w};

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_prev_reg <= `EIRQ_RESET_LEVEL;
      rx_prev_reg <= `EIRQ_RESET_LEVEL;
      tx_evt_reg  <= `EIRQ_RESET_LEVEL;
      rx_evt_reg  <= `EIRQ_RESET_LEVEL;
      cpu_reg     <= '0;
      chan_reg    <= '0;
      status_reg  <= '0;
    end
    else
    begin
      tx_prev_reg <= tx_comb_w;
      rx_prev_reg <= rx_comb_w;
      tx_evt_reg  <= tx_rise_w;
      rx_evt_reg  <= rx_rise_w;
      cpu_reg     <= cpu_next;
      chan_reg    <= chan_pend; // R4
      status_reg  <= status_next;
    end
  end

  assign combined_tx_irq    = tx_comb_w; // R1
  assign combined_rx_irq    = rx_comb_w; // R2
  assign tx_capture_evt     = tx_evt_reg;
  assign rx_capture_evt     = rx_evt_reg;
  assign cpu_irq_controller = cpu_reg;
  assign chan_pend_out      = chan_reg;
  assign status             = status_reg;

endmodule : eirq_combine_top

/* File: eirq_combine_sva.sv */
`timescale 1ns/1ps
module eirq_combine_sva
  import eirq_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire eirq_pkg::eirq_chan_t chan_pend,
  input wire logic                 pace_en_tx,
  input wire logic                 pace_en_rx,
  input wire logic                 combined_tx_irq,
  input wire logic                 combined_rx_irq,
  input wire logic                 tx_capture_evt,
  input wire logic                 rx_capture_evt,
  input wire eirq_pkg::eirq_cpu_t  cpu_irq_controller,
  input wire eirq_pkg::eirq_chan_t chan_pend_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_tx_pulse;
    tx_capture_evt ##1 !tx_capture_evt;
  endsequence
  sequence s_rx_pulse;
    rx_capture_evt ##1 !rx_capture_evt;
  endsequence
  // Pacing may hold a line low, so the plain merge is only checked unpaced.
  AST_TX_MERGE: assert property (
    !$past(rst) && !$past(pace_en_tx) && !$past(pace_en_tx, 2)
    |-> combined_tx_irq == $past(|chan_pend.tx_channel_irq))
    else $error("combined tx does not follow the channel lines");
  AST_RX_MERGE: assert property (
    !$past(rst) && !$past(pace_en_rx) && !$past(pace_en_rx, 2)
    |-> combined_rx_irq == $past(|chan_pend.rx_channel_irq))
    else $error("combined rx does not follow the channel lines");
  AST_TX_HOLD: assert property (
    combined_tx_irq && |chan_pend.tx_channel_irq |=> combined_tx_irq)
    else $error("combined tx dropped while a line pends");
  AST_RX_HOLD: assert property (
    combined_rx_irq && |chan_pend.rx_channel_irq |=> combined_rx_irq)
    else $error("combined rx dropped while a line pends");
  AST_TX_EVT: assert property ($rose(combined_tx_irq) |=> s_tx_pulse)
    else $error("tx capture pulse missing or too long");
  AST_RX_EVT: assert property ($rose(combined_rx_irq) |=> s_rx_pulse)
    else $error("rx capture pulse missing or too long");
  AST_CPU_CH0: assert property (
    !$past(rst) |-> cpu_irq_controller ==
    {$past(chan_pend.tx_channel_irq[0]), $past(chan_pend.rx_channel_irq[0])})
    else $error("channel 0 lines to the processor are wrong");
  AST_CHAN_COPY: assert property (
    !$past(rst) |-> chan_pend_out == $past(chan_pend))
    else $error("per-channel copy is not an unpaced delay");
endmodule : eirq_combine_sva

/* File: eirq_timer_model.sv */
`timescale 1ns/1ps
module eirq_timer_model #(
  parameter int RX_EVT_SEL = 8,
  parameter int TX_EVT_SEL = 9
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] evt_bus,
  output logic [7:0]       irq93_cnt,
  output logic [7:0]       irq94_cnt
);
  logic rx_prev_reg;
  logic tx_prev_reg;
  wire logic rx_sel = evt_bus[RX_EVT_SEL];
  wire logic tx_sel = evt_bus[TX_EVT_SEL];
  // No timer value is kept: only the capture notification counts.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      {rx_prev_reg, tx_prev_reg} <= 2'b00;
      {irq93_cnt, irq94_cnt} <= 16'h0000;
    end
    else
    begin
      rx_prev_reg <= rx_sel;
      tx_prev_reg <= tx_sel;
      irq93_cnt <= irq93_cnt + 8'(rx_sel && !rx_prev_reg);
      irq94_cnt <= irq94_cnt + 8'(tx_sel && !tx_prev_reg);
    end
  end
endmodule : eirq_timer_model

/* File: eirq_combine_top_tb.sv */
`timescale 1ns/1ps
module eirq_combine_top_tb;
  import eirq_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  eirq_chan_t chan_pend = '0;
  logic       pace_en_tx = 1'b0;
  logic       pace_en_rx = 1'b0;
  logic       combined_tx_irq, combined_rx_irq, tx_capture_evt, rx_capture_evt;
  eirq_cpu_t  cpu_irq_controller;
  eirq_chan_t chan_pend_out;
  eirq_status_t status;
  logic [7:0] irq93_cnt, irq94_cnt;
  int         fail_count = 0;
  int         total_checks = 0;
  wire logic [15:0] evt_bus = {6'h00, tx_capture_evt, rx_capture_evt, 8'h00};

  always #5 sys_clk = ~sys_clk;
  eirq_combine_top #(.PACE_CYCLES(3)) u_eirq_combine_top (.sys_clk, .rst,
    .chan_pend, .pace_en_tx, .pace_en_rx, .combined_tx_irq, .combined_rx_irq,
    .tx_capture_evt, .rx_capture_evt, .cpu_irq_controller, .chan_pend_out,
    .status);
  eirq_timer_model u_eirq_timer_model (.sys_clk, .rst, .evt_bus, .irq93_cnt,
    .irq94_cnt);

  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Launch on one edge, look just after the edge that samples it.
  task automatic drive(input eirq_chan_t v);
    @(posedge sys_clk);
    chan_pend <= v;
    @(posedge sys_clk);
    #1;
  endtask : drive
  task automatic sweep_channels;
    for (int i = 0; i < 8; i++)
    begin
      drive({8'h01 << i, 8'h80 >> i});
      check({combined_tx_irq, combined_rx_irq}, 16'h0003);
      check(cpu_irq_controller, {i == 0, i == 7});
      check(status, {8'h11, 3'(i), 3'(7 - i), 2'b00});
      drive('0);
      check({combined_tx_irq, combined_rx_irq}, 16'h0000);
    end
    check({irq94_cnt, irq93_cnt}, 16'h0808);
  endtask : sweep_channels
  task automatic hold_until_clear;
    drive({8'h24, 8'h24});
    check(status, 16'h2248);
    drive({8'h20, 8'h04});
    check({combined_tx_irq, combined_rx_irq}, 16'h0003);
    check(status, 16'h11a8);
    drive('0);
    check({combined_tx_irq, combined_rx_irq}, 16'h0000);
  endtask : hold_until_clear
  task automatic pace_gap;
    int n;
    n = 0;
    @(posedge sys_clk);
    pace_en_tx <= 1'b1;
    pace_en_rx <= 1'b1;
    drive({8'h01, 8'h01});
    drive('0);
    drive({8'h01, 8'h01});
    check({combined_tx_irq, combined_rx_irq}, 16'h0000);
    check(cpu_irq_controller, 16'h0003);
    check(status, 16'h1103);
    while (combined_tx_irq !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 8)
    begin
      fail_count++;
      finish_test();
    end
    check(16'(n), 16'h0001);
    check(combined_rx_irq, 16'h0001);
    @(posedge sys_clk);
    pace_en_tx <= 1'b0;
    pace_en_rx <= 1'b0;
    drive('0);
  endtask : pace_gap
  // Reset in mid-run with lines pending, then release with them still set.
  task automatic reset_midrun;
    drive({8'hff, 8'hff});
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    check({combined_tx_irq, combined_rx_irq}, 16'h0000);
    check({tx_capture_evt, rx_capture_evt}, 16'h0000);
    check(cpu_irq_controller, 16'h0000);
    check(chan_pend_out, 16'h0000);
    @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({combined_tx_irq, combined_rx_irq}, 16'h0003);
    check(cpu_irq_controller, 16'h0003);
    check(chan_pend_out, 16'hffff);
    drive('0);
    check({irq94_cnt, irq93_cnt}, 16'h0101);
    check({combined_tx_irq, combined_rx_irq}, 16'h0000);
  endtask : reset_midrun

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    sweep_channels();
    hold_until_clear();
    pace_gap();
    reset_midrun();
    finish_test();
  end
endmodule : eirq_combine_top_tb

bind eirq_combine_top eirq_combine_sva u_eirq_combine_sva (.sys_clk, .rst,
  .chan_pend, .pace_en_tx, .pace_en_rx, .combined_tx_irq, .combined_rx_irq,
  .tx_capture_evt, .rx_capture_evt, .cpu_irq_controller, .chan_pend_out);
